// ===== hdl/ppxs_map.vh
// Constants for the program page expansion and chip select block.
// Assumes inclusion by the block's single design file only.
`ifndef PPXS_MAP_VH
`define PPXS_MAP_VH
`define PPXS_PAGE_BITS      6
`define PPXS_PAGE_RESET     6'h00
`define PPXS_PAGE_TOP       6'h3F
`define PPXS_WIN_ADDR_HI    2'h2
`define PPXS_UNPAGED_HI     2'h3
`define PPXS_LOW_HI         2'h0
`define PPXS_MID_HI         2'h1
`define PPXS_XAB_LOW        6'h3D
`define PPXS_XAB_MID        6'h3E
`define PPXS_XAB_TOP        6'h3F
`define PPXS_SPLIT_00       6'h38
`define PPXS_SPLIT_01       6'h30
`define PPXS_SPLIT_10       6'h20
`define PPXS_ALLOC_0K       2'h0
`define PPXS_ALLOC_16K      2'h1
`define PPXS_ALLOC_48K      2'h2
`define PPXS_ALLOC_64K      2'h3
`define PPXS_CS_BIT_EMU     7
`define PPXS_CS_BIT_EXT     6
`endif

// ===== hdl/ppxs_core.v
// Program page index register, paged call/return sequencing and the two
// off-chip chip selects that may be switched onto port K.
// Assumes all inputs are synchronous to ref_clk; the CPU core presents one
// address per cycle together with the decode flags of higher-priority blocks.
`include "ppxs_map.vh"
`timescale 1ns/1ps
`default_nettype none

// Function
// (R01) Port K bit 7 is emulation select
// (R02) Emulation select needs emulation mode, enable, flash
// (R03) Port K bit 6 is external select
// (R04) External select only when emulation select idle
// (R05) Unimplemented or removed locations never select external
// (R06) Enable clear leaves both pins general I/O
// (R07) Page index places 16K block in window
// (R08) Straps give on-chip/off-chip split
// (R09) Index threshold classifies window internal or external
// (R10) Page register via load/store and call/return
// (R11) Top 16K block never paged
// (R12) Software keeps vectors in unpaged memory
// (R13) Software keeps stack and I/O unpaged
// (R14) Call latches old page, loads new, pushes
// (R15) Call and return sequences are not interruptible
// (R16) Call page from immediate or indirect pointer
// (R17) Return pulls page, address, restores page
// (R18) Page index picks one of 64 pages
// (R19) Software enters paged routines only by call
// (R20) Normal write effective next cycle; call/return sooner; here a call loads at the write's edge, a return three edges later
// (R21) Expansion window has lowest select priority
// (R22) Window routing follows classification
module ppxs_core #(
	parameter PAGE_BITS = `PPXS_PAGE_BITS
)(
	input  wire                 ref_clk,             // System clock, 100 MHz
	input  wire                 srst,                // Synchronous reset, active high
	input  wire [1:0]           paging_partition_straps, // Off/on-chip split straps
	input  wire [1:0]           flash_alloc_straps,  // Allocated physical flash size
	input  wire                 flash_high_map,      // Flash mapped high-only control
	input  wire                 emulation_mode,      // System is in emulation mode
	input  wire                 expanded_mode,       // System is in an expanded mode
	input  wire                 emulation_port_k_enable, // Port K carries selects
	input  wire                 addr_valid,          // Core access present this cycle
	input  wire [15:0]          addr,                // Core physical address
	input  wire                 hi_prio_hit,         // Register/RAM/EEPROM/vector select won
	input  wire                 unimpl_or_removed,   // Unimplemented or removed location
	input  wire                 page_wr,             // Ordinary store to page register
	input  wire [PAGE_BITS-1:0] page_wr_data,        // Data of that store
	input  wire                 call_start,          // Paged call begins
	input  wire [PAGE_BITS-1:0] call_page,           // New page (immediate or fetched)
	input  wire [15:0]          call_ret_addr,       // Return address to stack
	input  wire                 rtc_start,           // Paged return begins
	input  wire [PAGE_BITS-1:0] stack_page,          // Page word pulled from the stack
	input  wire [15:0]          stack_addr,          // Return address pulled from stack
	input  wire [1:0]           gpio_k_out,          // General purpose K7:K6 out values
	input  wire [1:0]           gpio_k_oe_n,         // General purpose K7:K6 enables, low=drive
	output reg  [PAGE_BITS-1:0] program_page_index_reg, // Current page index
	output reg                  busy_reg,            // Call/return sequence in progress
	output reg                  irq_block_reg,       // Interrupts held off
	output reg                  push_valid_reg,      // Stack push strobe
	output reg  [15:0]          push_data_reg,       // Word pushed
	output reg                  pull_req_reg,        // Stack pull request
	output reg                  pc_load_reg,         // Load program counter strobe
	output reg  [15:0]          pc_value_reg,        // Program counter value
	output reg                  queue_refill_reg,    // Instruction queue refill strobe
	output reg                  onchip_flash_sel_reg, // On-chip flash/ROM select
	output reg                  offchip_sel_reg,     // Off-chip window select path
	output reg  [5:0]           extended_address_high, // Extended address to port K5:0
	output reg  [1:0]           port_k_hi_out,       // Port K bits 7:6 drive value
	output reg  [1:0]           port_k_hi_oe_n       // Port K bits 7:6 enable, low=drive
);

	localparam S_IDLE  = 7'b000_0001;
	localparam S_CRET  = 7'b000_0010;
	localparam S_CPAGE = 7'b000_0100;
	localparam S_CJUMP = 7'b000_1000;
	localparam S_RPULL = 7'b001_0000;
	localparam S_RADDR = 7'b010_0000;
	localparam S_RDONE = 7'b100_0000;

	reg [6:0]           state_reg;
	reg [6:0]           state_next;
	reg [PAGE_BITS-1:0] old_page_reg;
	reg [PAGE_BITS-1:0] rtc_page_reg;
	reg [15:0]          ret_addr_reg;

	// Window is internal when the page index reaches the strap threshold.
	function win_internal;
		input [1:0]           straps;
		input [PAGE_BITS-1:0] page;
		begin
			case (straps)
				2'b00:   win_internal = (page >= `PPXS_SPLIT_00); // [R09] [R08]
				2'b01:   win_internal = (page >= `PPXS_SPLIT_01); // [R09] [R08]
				2'b10:   win_internal = (page >= `PPXS_SPLIT_10); // [R09] [R08]
				default: win_internal = 1'b1;                     // [R09] [R08]
			endcase
		end
	endfunction

	wire [1:0] quad    = addr[15:14];
	wire       in_win  = (quad == `PPXS_WIN_ADDR_HI);
	wire       win_int = win_internal(paging_partition_straps, program_page_index_reg);
	wire       cs_live = emulation_port_k_enable && expanded_mode;

	// Emulation select follows the allocated flash size table.
	reg emu_hit;
	always @*
	begin
		emu_hit = 1'b0;
		case (flash_alloc_straps)
			`PPXS_ALLOC_0K:  emu_hit = in_win || (quad == `PPXS_UNPAGED_HI);
			`PPXS_ALLOC_16K: emu_hit = (quad == `PPXS_UNPAGED_HI);
			`PPXS_ALLOC_48K: emu_hit = (quad == `PPXS_UNPAGED_HI) || (in_win && win_int)
				|| ((quad == `PPXS_MID_HI) && !flash_high_map);
			default:         emu_hit = (quad == `PPXS_UNPAGED_HI) || (in_win && win_int)
				|| ((quad != `PPXS_WIN_ADDR_HI) && !flash_high_map);
		endcase
	end

	wire emu_act = addr_valid && emulation_mode && cs_live && emu_hit; // [R02]
	// External means no internal block claimed it and it is a real location.
	wire ext_act = addr_valid && cs_live && !emu_act && !hi_prio_hit
		&& !unimpl_or_removed && !(in_win && win_int); // [R04] [R05] [R21]

	always @*
	begin
		state_next = state_reg;
		case (state_reg)
			S_IDLE:
				if (call_start)
					state_next = S_CRET;
				else if (rtc_start)
					state_next = S_RPULL;
			S_CRET:  state_next = S_CPAGE;
			S_CPAGE: state_next = S_CJUMP;
			S_CJUMP: state_next = S_IDLE;
			S_RPULL: state_next = S_RADDR;
			S_RADDR: state_next = S_RDONE;
			S_RDONE: state_next = S_IDLE;
			default: state_next = S_IDLE;
		endcase
	end

	always @(posedge ref_clk)
	begin
		if (srst)
		begin
			state_reg              <= S_IDLE;
			program_page_index_reg <= `PPXS_PAGE_RESET;
			old_page_reg           <= `PPXS_PAGE_RESET;
			rtc_page_reg           <= `PPXS_PAGE_RESET;
			ret_addr_reg           <= 16'h0000;
			busy_reg               <= 1'b0;
			irq_block_reg          <= 1'b0;
			push_valid_reg         <= 1'b0;
			push_data_reg          <= 16'h0000;
			pull_req_reg           <= 1'b0;
			pc_load_reg            <= 1'b0;
			pc_value_reg           <= 16'h0000;
			queue_refill_reg       <= 1'b0;
			onchip_flash_sel_reg   <= 1'b0;
			offchip_sel_reg        <= 1'b0;
			extended_address_high  <= 6'h00;
			port_k_hi_out          <= 2'b11;
			port_k_hi_oe_n         <= 2'b11;
		end
		else
		begin
			state_reg        <= state_next;
			push_valid_reg   <= 1'b0;
			pull_req_reg     <= 1'b0;
			pc_load_reg      <= 1'b0;
			queue_refill_reg <= 1'b0;
			busy_reg         <= (state_next != S_IDLE);
			irq_block_reg    <= (state_next != S_IDLE); // [R15]
			case (state_reg)
				S_IDLE:
					if (call_start)
					begin
						old_page_reg           <= program_page_index_reg; // [R14]
						program_page_index_reg <= call_page;              // [R14] [R16]
						ret_addr_reg           <= call_ret_addr;
					end
					else if (rtc_start)
						pull_req_reg <= 1'b1; // [R17]
					else if (page_wr)
						program_page_index_reg <= page_wr_data; // [R10] [R20]
				S_CRET:
				begin
					push_valid_reg <= 1'b1;         // [R14]
					push_data_reg  <= ret_addr_reg; // [R14]
				end
				S_CPAGE:
				begin
					push_valid_reg <= 1'b1;                                // [R14]
					push_data_reg  <= {{(16-PAGE_BITS){1'b0}}, old_page_reg}; // [R14]
				end
				S_CJUMP:
					queue_refill_reg <= 1'b1; // [R14]
				S_RPULL:
				begin
					rtc_page_reg <= stack_page; // [R17]
					pull_req_reg <= 1'b1;
				end
				S_RADDR:
				begin
					pc_load_reg  <= 1'b1;       // [R17]
					pc_value_reg <= stack_addr; // [R17]
				end
				S_RDONE:
				begin
					program_page_index_reg <= rtc_page_reg; // [R17] [R20]
					queue_refill_reg       <= 1'b1;
				end
				default: ;
			endcase

			// Window selects lose to any higher-priority block at the same address.
			onchip_flash_sel_reg <= addr_valid && in_win && win_int && !hi_prio_hit; // [R22] [R21] [R07] [R18]
			offchip_sel_reg      <= addr_valid && in_win && !win_int && !hi_prio_hit; // [R22] [R21]

			case (quad)
				`PPXS_LOW_HI:     extended_address_high <= `PPXS_XAB_LOW;
				`PPXS_MID_HI:     extended_address_high <= `PPXS_XAB_MID;
				`PPXS_WIN_ADDR_HI: extended_address_high <= program_page_index_reg; // [R07] [R18]
				default:          extended_address_high <= `PPXS_XAB_TOP;           // [R11]
			endcase

			if (emulation_port_k_enable)
			begin
				port_k_hi_out  <= {!emu_act, !ext_act}; // [R01] [R03]
				port_k_hi_oe_n <= 2'b00;                // [R01] [R03]
			end
			else
			begin
				port_k_hi_out  <= gpio_k_out;  // [R06]
				port_k_hi_oe_n <= gpio_k_oe_n; // [R06]
			end
		end
	end

endmodule

`default_nettype wire

// ===== sim/ppxs_core_assertions.sv
// Concurrent checks on the ports of the page and chip select block.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module ppxs_chk (
	input wire logic        ref_clk, srst,                               // Clock, reset
	input wire logic [1:0]  paging_partition_straps, gpio_k_out, gpio_k_oe_n, // Straps, I/O
	input wire logic        emulation_mode, expanded_mode, emulation_port_k_enable, // Modes
	input wire logic        addr_valid, hi_prio_hit, unimpl_or_removed, // Access flags
	input wire logic [15:0] addr, call_ret_addr, push_data_reg,         // Words
	input wire logic        page_wr, call_start, rtc_start, busy_reg,   // Requests
	input wire logic        irq_block_reg, push_valid_reg, pull_req_reg, // Strobes
	input wire logic        pc_load_reg, queue_refill_reg,              // Strobes
	input wire logic        onchip_flash_sel_reg, offchip_sel_reg,      // Window selects
	input wire logic [5:0]  page_wr_data, call_page,                    // New pages
	input wire logic [5:0]  program_page_index_reg,                     // Page index
	input wire logic [1:0]  port_k_hi_out, port_k_hi_oe_n               // Port K 7:6
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);
	wire       idle = !busy_reg;
	wire [1:0] st   = paging_partition_straps;
	wire [5:0] thr  = st == 2'h0 ? 6'h38 : st == 2'h1 ? 6'h30 : 6'h20;
	wire       inw  = st == 2'h3 || program_page_index_reg >= thr;
	wire       win  = addr_valid && addr[15:14] == 2'h2 && !hi_prio_hit && !unimpl_or_removed;
	sequence s_push;
		push_valid_reg && push_data_reg == $past(call_ret_addr, 2) ##1
		push_valid_reg && push_data_reg == {10'h000, $past(program_page_index_reg, 3)};
	endsequence
	sequence s_rtc; pull_req_reg ##2 pc_load_reg ##1 queue_refill_reg; endsequence
	property p_call; call_start && idle |=> program_page_index_reg == $past(call_page)
		##1 s_push ##1 queue_refill_reg; endproperty
	a_call: assert property (p_call) else $error("call sequence");
	property p_rtc; rtc_start && idle && !call_start |=> s_rtc; endproperty
	a_rtc: assert property (p_rtc) else $error("return sequence");
	property p_wr; page_wr && idle && !call_start && !rtc_start
		|=> program_page_index_reg == $past(page_wr_data); endproperty
	a_wr: assert property (p_wr) else $error("page write");
	property p_irq; busy_reg |-> irq_block_reg; endproperty
	a_irq: assert property (p_irq) else $error("interrupt held");
	property p_gpio; !emulation_port_k_enable |=> port_k_hi_out == $past(gpio_k_out)
		&& port_k_hi_oe_n == $past(gpio_k_oe_n); endproperty
	a_gpio: assert property (p_gpio) else $error("general pins");
	property p_eoff; emulation_port_k_enable && !emulation_mode |=> port_k_hi_out[1]; endproperty
	a_eoff: assert property (p_eoff) else $error("emulation select");
	property p_eon; emulation_port_k_enable && emulation_mode && expanded_mode && addr_valid
		&& addr[15:14] == 2'h3 && !hi_prio_hit |=> !port_k_hi_out[1]; endproperty
	a_eon: assert property (p_eon) else $error("emulation select top");
	property p_unim; emulation_port_k_enable && unimpl_or_removed |=> port_k_hi_out[0]; endproperty
	a_unim: assert property (p_unim) else $error("external select");
	property p_win; win |=> onchip_flash_sel_reg == $past(inw)
		&& offchip_sel_reg == !$past(inw); endproperty
	a_win: assert property (p_win) else $error("window routing");
endmodule
bind ppxs_core ppxs_chk u_chk (.*);
`default_nettype wire

// ===== sim/ppxs_stack.sv
// Stack memory model answering the block's push and pull strobes.
// Assumes single-cycle strobes; the top word stands while a pull is requested.
`timescale 1ns/1ps
`default_nettype none
module ppxs_stack (
	input  wire logic        ref_clk,    // Clock
	input  wire logic        push_valid, // Push strobe
	input  wire logic [15:0] push_data,  // Pushed word
	input  wire logic        pull_req,   // Pull strobe
	output wire logic [15:0] pull_data   // Pulled word
);
	logic [15:0] mem [0:7];
	logic [2:0]  sp = 3'h0;
	// The block samples the word at the same edge that takes the pull strobe.
	assign pull_data = mem[sp - 3'h1];
	// The stack sits in unpaged space, so page changes never move it.
	always @(posedge ref_clk)
	begin
		if (push_valid)
		begin
			mem[sp] <= push_data;
			sp <= sp + 3'h1;
		end
		else if (pull_req)
			sp <= sp - 3'h1;
	end
endmodule
`default_nettype wire

// ===== sim/ppxs_tb.sv
// Self-checking bench for the page and chip select block.
// Assumes the stack model stands on the far side of the push/pull strobes.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic ref_clk = 1'b0, srst = 1'b1, flash_high_map = 1'b0, emulation_mode = 1'b0;
	logic [1:0] paging_partition_straps = 2'h0, flash_alloc_straps = 2'h3;
	logic [1:0] gpio_k_out = 2'h0, gpio_k_oe_n = 2'h3, port_k_hi_out, port_k_hi_oe_n;
	logic expanded_mode = 1'b0, emulation_port_k_enable = 1'b0, addr_valid = 1'b0;
	logic hi_prio_hit = 1'b0, unimpl_or_removed = 1'b0, page_wr = 1'b0;
	logic call_start = 1'b0, rtc_start = 1'b0, busy_reg, irq_block_reg, push_valid_reg;
	logic pull_req_reg, pc_load_reg, queue_refill_reg, onchip_flash_sel_reg, offchip_sel_reg;
	logic [15:0] addr = 16'h0000, call_ret_addr = 16'h0000, pull_data, push_data_reg;
	logic [15:0] pc_value_reg, pcv;
	logic [5:0] page_wr_data = 6'h00, call_page = 6'h00, program_page_index_reg;
	logic [5:0] extended_address_high, thr [4] = '{6'h38, 6'h30, 6'h20, 6'h00};
	logic [3:0] emu_tab [5] = '{4'h3, 4'h7, 4'h5, 4'h4, 4'h7};
	logic [5:0] xab_tab [4] = '{6'h3D, 6'h3E, 6'h05, 6'h3F};
	wire  [5:0] stack_page = pull_data[5:0];
	wire [15:0] stack_addr = pull_data;
	int errors = 0, num_checks = 0, i, s, k;
	ppxs_core uut (.*);
	ppxs_stack stk (.ref_clk(ref_clk), .push_valid(push_valid_reg), .push_data(push_data_reg),
		.pull_req(pull_req_reg), .pull_data(pull_data));
	always #5 ref_clk = ~ref_clk;
	task cyc(input int n); repeat (n) @(negedge ref_clk); endtask
	task chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task setpg(input logic [5:0] p);
		page_wr = 1'b1;
		page_wr_data = p;
		cyc(1);
		page_wr = 1'b0;
	endtask
	task finish_test;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task t_call_rtc;
		setpg(6'h3F);
		chk(program_page_index_reg, 6'h3F);
		{call_page, call_ret_addr, call_start} = {6'h15, 16'h1234, 1'b1};
		cyc(1);
		call_start = 1'b0;
		chk(program_page_index_reg, 6'h15);
		chk(irq_block_reg, 1'b1);
		setpg(6'h00);
		for (i = 0; i < 20 && busy_reg !== 1'b0; i++) cyc(1);
		chk(program_page_index_reg, 6'h15);
		chk(stk.mem[0], 16'h1234);
		chk(stk.mem[1], 16'h003F);
		rtc_start = 1'b1;
		cyc(1);
		rtc_start = 1'b0;
		for (i = 0; i < 20 && busy_reg !== 1'b0; i++)
		begin
			if (pc_load_reg === 1'b1) pcv = pc_value_reg;
			cyc(1);
		end
		chk(pcv, 16'h1234);
		chk(program_page_index_reg, 6'h3F);
		$display("call and return done");
	endtask
	task t_win;
		{addr, addr_valid} = {16'h8000, 1'b1};
		for (s = 0; s < 4; s++)
			for (k = 0; k < 2; k++)
			begin
				paging_partition_straps = s[1:0];
				setpg(thr[s] - k[5:0]);
				cyc(1);
				chk({onchip_flash_sel_reg, offchip_sel_reg}, (s == 3 || k == 0) ? 2'h2 : 2'h1);
			end
		$display("window split done");
	endtask
	task t_cs;
		{emulation_port_k_enable, expanded_mode, emulation_mode, addr} = {3'h7, 16'hC000};
		cyc(1);
		chk({port_k_hi_out, port_k_hi_oe_n}, 4'h4);
		chk(extended_address_high, 6'h3F);
		{emulation_mode, paging_partition_straps, addr} = {3'h0, 16'h8000};
		setpg(6'h05);
		cyc(1);
		chk(port_k_hi_out, 2'h2);
		chk(extended_address_high, 6'h05);
		unimpl_or_removed = 1'b1;
		cyc(1);
		chk(port_k_hi_out, 2'h3);
		{unimpl_or_removed, hi_prio_hit} = 2'h1;
		cyc(1);
		chk({port_k_hi_out, offchip_sel_reg}, 3'h6);
		{emulation_port_k_enable, gpio_k_out, gpio_k_oe_n} = {1'b0, 4'h9};
		cyc(1);
		chk({port_k_hi_out, port_k_hi_oe_n}, 4'h9);
		$display("chip selects done");
	endtask
	// Emulation select per allocation, last pass with flash mapped high only.
	task t_emu;
		{emulation_port_k_enable, emulation_mode, hi_prio_hit} = 3'h6;
		for (s = 0; s < 5; s++)
			for (k = 0; k < 4; k++)
			begin
				{flash_alloc_straps, flash_high_map} = {s[1:0] | {2{s[2]}}, s[2]};
				addr = {k[1:0], 14'h0000};
				cyc(1);
				chk(port_k_hi_out[1], emu_tab[s][k]);
				chk(extended_address_high, xab_tab[k]);
			end
		$display("emulation select done");
	endtask
	initial
	begin
		#20000;
		errors++;
		finish_test;
	end
	initial
	begin
		cyc(12);
		srst = 1'b0;
		chk({program_page_index_reg, port_k_hi_out}, 8'h03);
		t_call_rtc;
		t_win;
		t_cs;
		t_emu;
		finish_test;
	end
endmodule
`default_nettype wire
